// [rtl/dsc_defs.svh]
// Timing figures, reset values and encodings of the dual converter sequencer
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// ==========================================================
// Timing
`define DSC_CLK_PERIOD_NS   40
`define DSC_OSC_PERIOD_NS   80

// ==========================================================
// Result widths of the two variants
`define DSC_RES_W_NARROW    12
`define DSC_RES_W_WIDE      14

// ==========================================================
// Input span codes, {sel1, sel0}
`define DSC_SPAN_BIP10      2'h0
`define DSC_SPAN_BIP5       2'h1
`define DSC_SPAN_UNI10      2'h2
`define DSC_SPAN_BAD        2'h3

// ==========================================================
// Reset values
`define DSC_PAIR_DEFAULT    1'h0
`define DSC_PIN_IDLE        1'h1

`endif

// [rtl/dsc_pkg.sv]
// Types shared by the dual converter sequencer and its converter core
package dsc_pkg;
  `include "dsc_defs.svh"

  // Input span selection
  typedef enum logic [1:0] {
    DSC_SPAN_BIP10 = `DSC_SPAN_BIP10,
    DSC_SPAN_BIP5  = `DSC_SPAN_BIP5,
    DSC_SPAN_UNI10 = `DSC_SPAN_UNI10,
    DSC_SPAN_BAD   = `DSC_SPAN_BAD
  } dsc_span_e_t;

  // Sequencer states
  typedef enum logic [1:0] {
    DSC_IDLE,
    DSC_CONV,
    DSC_PDOWN
  } dsc_seq_t;

  // Host pins that cross into the system clock domain together
  typedef struct packed {
    logic        conv_trigger_n;
    logic        frame_sel_n;
    logic        serial_clk;
    logic        reference_source_sel;
    logic [1:0]  input_span_sel;
    logic        pair_sel;
  } dsc_pins_t;
endpackage : dsc_pkg

// [rtl/dsc_sar_core.sv]
// One successive approximation converter clocked by the system clock, its internal oscillator period counted out in system clocks
`timescale 1ns/100ps
`include "dsc_defs.svh"
module dsc_sar_core #(
  parameter int RES_W = `DSC_RES_W_WIDE
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic [RES_W-1:0] sample,
  output logic      [RES_W-1:0] result,
  output logic                  done
);
  import dsc_pkg::*;

  // ==========================================================
  // Oscillator period in system clocks, rounded up
  localparam int OSC_CYC = (`DSC_OSC_PERIOD_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS;
  localparam int OSC_W   = (OSC_CYC > 1) ? $clog2(OSC_CYC) : 1;

  if (RES_W != `DSC_RES_W_NARROW && RES_W != `DSC_RES_W_WIDE) begin : g_bad_width
    $error("dsc_sar_core: result width must be 12 or 14");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic             active;   // Conversion running
    logic [OSC_W-1:0] osc;      // Oscillator phase
    logic [RES_W-1:0] mask;     // Bit under trial
    logic [RES_W-1:0] code;     // Offset binary code so far
    logic [RES_W-1:0] result;   // Two's complement result
    logic             done;     // End of conversion pulse
  } dsc_sar_st_t;

  dsc_sar_st_t q, d;
  logic tick;
  logic [RES_W-1:0] trial;

  // Next state: one bit decided per oscillator period
  always_comb begin
    d     = q;
    d.done = 1'h0;
    tick  = (q.osc == OSC_W'(OSC_CYC - 1));
    trial = q.code | q.mask;
    if (start) begin
      d.active = 1'h1;
      d.osc    = '0;
      d.mask   = {1'h1, {(RES_W-1){1'h0}}};
      d.code   = '0;
    end else if (q.active) begin
      d.osc = tick ? '0 : OSC_W'(q.osc + 1'h1);
      if (tick) begin
        if (sample >= trial) begin
          d.code = trial;
        end
        d.mask = q.mask >> 1;
        if (q.mask[0]) begin
          // Offset binary to two's complement: invert the top bit
          d.active = 1'h0;
          d.done   = 1'h1;
          d.result = {~d.code[RES_W-1], d.code[RES_W-2:0]};
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign result = q.result;
  assign done   = q.done;
endmodule : dsc_sar_core

// [rtl/dsc_sequencer.sv]
// Conversion sequencer and serial readout of a dual simultaneous sampling converter
`timescale 1ns/100ps
`include "dsc_defs.svh"
module dsc_sequencer #(
  parameter int RES_W = `DSC_RES_W_WIDE
) (
  input  wire logic                CLK_SYS,
  input  wire logic                RST_N,
  input  wire logic                CONV_TRIGGER_N,
  input  wire logic                FRAME_SEL_N,
  input  wire logic                SERIAL_CLK,
  input  wire logic                REFERENCE_SOURCE_SEL,
  input  wire logic                INPUT_SPAN_SEL0,
  input  wire logic                INPUT_SPAN_SEL1,
  input  wire logic                PAIR_SEL,
  input  wire logic [RES_W-1:0]    INPUT_A1,
  input  wire logic [RES_W-1:0]    INPUT_A2,
  input  wire logic [RES_W-1:0]    INPUT_B1,
  input  wire logic [RES_W-1:0]    INPUT_B2,
  output logic                     BUSY,
  output logic                     HOLD,
  output logic                     POWER_DOWN,
  output logic                     RESULT_OUT_A,
  output logic                     RESULT_OUT_A_OE,
  output logic                     RESULT_OUT_B,
  output logic                     RESULT_OUT_B_OE,
  output logic                     REF_INTERNAL,
  output dsc_pkg::dsc_span_e_t     SPAN_ACTIVE,
  output logic                     SPAN_FAULT,
  output logic                     PAIR_ACTIVE
);
  import dsc_pkg::*;

  // ==========================================================
  // Parameter checks
  // Only the two result widths of the family are served by the shift and core logic
  if (RES_W != `DSC_RES_W_NARROW && RES_W != `DSC_RES_W_WIDE) begin : g_bad_width
    $error("dsc_sequencer: result width must be 12 or 14");
  end

  // ==========================================================
  // State of the sequencer
  typedef struct packed {
    dsc_pins_t        meta;       // First synchroniser stage
    dsc_pins_t        sync;       // Second synchroniser stage
    dsc_pins_t        prev;       // Delayed copy for edge finding
    dsc_seq_t         seq;        // Sequencer state
    logic             busy;       // Busy flag
    logic             hold;       // Sample stages holding
    logic             pdown;      // Powered down
    logic             start;      // Start pulse to both cores
    logic             pair_cur;   // Pair used by this conversion
    logic             pair_next;  // Pair latched for the next one
    dsc_span_e_t      span;       // Span in use
    logic             span_bad;   // Forbidden span seen at start
    logic             ref_int;    // Reference source in use
    logic [RES_W-1:0] held_a;     // Held sample, converter A
    logic [RES_W-1:0] held_b;     // Held sample, converter B
    logic [RES_W-1:0] res_a;      // Last result, converter A
    logic [RES_W-1:0] res_b;      // Last result, converter B
    logic [RES_W-1:0] sh_a;       // Shift register, line A
    logic [RES_W-1:0] sh_b;       // Shift register, line B
    logic             out_a;      // Line A data
    logic             out_b;      // Line B data
    logic             oe;         // Drivers enabled
  } dsc_seq_st_t;

  dsc_seq_st_t      q, d;
  dsc_pins_t        pins_now;     // Raw pins gathered
  logic             trig_fall;    // Trigger falling edge
  logic             trig_rise;    // Trigger rising edge
  logic             frame_fall;   // Frame select falling edge
  logic             sclk_fall;    // Serial clock falling edge
  logic [RES_W-1:0] core_res_a;   // Core A result
  logic [RES_W-1:0] core_res_b;   // Core B result
  logic             core_done_a;  // Core A end of conversion
  logic             core_done_b;  // Core B end of conversion

  // ==========================================================
  // Helpers

  // Falling edge between delayed and current synchronised level
  function automatic logic fell(input logic prev_lvl, input logic cur_lvl);
    fell = prev_lvl & ~cur_lvl;
  endfunction : fell

  // Pick the sample of the selected pair
  // Used for both converters so the two pairs can never be mixed
  function automatic logic [RES_W-1:0] pick(input logic sel,
                                            input logic [RES_W-1:0] first,
                                            input logic [RES_W-1:0] second);
    pick = sel ? second : first;
  endfunction : pick

  // ==========================================================
  // Pin gathering
  // Every host pin is asynchronous to CLK_SYS; gathered so all share one synchroniser
  always_comb begin
    pins_now                      = '0;
    pins_now.conv_trigger_n       = CONV_TRIGGER_N;
    pins_now.frame_sel_n          = FRAME_SEL_N;
    pins_now.serial_clk           = SERIAL_CLK;
    pins_now.reference_source_sel = REFERENCE_SOURCE_SEL;
    pins_now.input_span_sel       = {INPUT_SPAN_SEL1, INPUT_SPAN_SEL0};
    pins_now.pair_sel             = PAIR_SEL;
  end

  // ==========================================================
  // Converter cores, both on the same internal timing
  // Same start pulse and same oscillator count, so both finish on the same edge
  dsc_sar_core #(
    .RES_W (RES_W)
  ) u_core_a (
    .clk    (CLK_SYS),
    .rst_n  (RST_N),
    .start  (q.start),
    .sample (q.held_a),
    .result (core_res_a),
    .done   (core_done_a)
  );

  dsc_sar_core #(
    .RES_W (RES_W)
  ) u_core_b (
    .clk    (CLK_SYS),
    .rst_n  (RST_N),
    .start  (q.start),
    .sample (q.held_b),
    .result (core_res_b),
    .done   (core_done_b)
  );

  // ==========================================================
  // Next state
  always_comb begin
    d = q;

    // Synchronisers: stage one feeds stage two only
    // Edge finders look at stage two and its delayed copy, never at stage one,
    // so a metastable first stage cannot reach the sequencer
    d.meta = pins_now;
    d.sync = q.meta;
    d.prev = q.sync;

    // Edges on synchronised pins
    trig_fall  = fell(q.prev.conv_trigger_n, q.sync.conv_trigger_n);
    trig_rise  = fell(q.sync.conv_trigger_n, q.prev.conv_trigger_n);
    frame_fall = fell(q.prev.frame_sel_n, q.sync.frame_sel_n);
    sclk_fall  = fell(q.prev.serial_clk, q.sync.serial_clk);

    // Reference source follows its strap level
    d.ref_int = q.sync.reference_source_sel;

    // Start pulse lasts one cycle
    // A longer pulse would restart the cores on every cycle it stands
    d.start = 1'h0;

    // Trigger falls outside IDLE are dropped on purpose: a fall while
    // converting would otherwise restart both cores half way through
    unique case (q.seq)
      // Waiting for a trigger
      DSC_IDLE: begin
        if (trig_fall) begin
          d.seq   = DSC_CONV;
          d.busy  = 1'h1;
          d.hold  = 1'h1;
          d.start = 1'h1;
          // Both inputs captured on the same edge
          d.held_a = pick(q.pair_next, INPUT_A1, INPUT_A2);
          d.held_b = pick(q.pair_next, INPUT_B1, INPUT_B2);
          // Pair latched last busy rise applies now, new one latched
          d.pair_cur  = q.pair_next;
          d.pair_next = q.sync.pair_sel;
          // Span is frozen per conversion; a change in between counts at the next start
          // Forbidden span keeps the old one and flags it
          if (q.sync.input_span_sel == `DSC_SPAN_BAD) begin
            d.span_bad = 1'h1;
          end else begin
            d.span_bad = 1'h0;
            d.span     = dsc_span_e_t'(q.sync.input_span_sel);
          end
        end
      end

      // Conversion in progress on the internal oscillator
      DSC_CONV: begin
        if (core_done_a && core_done_b) begin
          d.busy  = 1'h0;
          d.hold  = 1'h0;
          // Results copied here so a later readout sees steady words
          d.res_a = core_res_a;
          d.res_b = core_res_b;
          // Trigger still low at the end means power down
          if (!q.sync.conv_trigger_n) begin
            d.seq   = DSC_PDOWN;
            d.pdown = 1'h1;
          end else begin
            d.seq = DSC_IDLE;
          end
        end
      end

      // Powered down until the trigger rises
      // A trigger fall alone does nothing here; the host raises it first
      DSC_PDOWN: begin
        if (trig_rise) begin
          d.seq   = DSC_IDLE;
          d.pdown = 1'h0;
        end
      end

      // Unused state code: back to waiting with nothing running
      default: begin
        d.seq   = DSC_IDLE;
        d.busy  = 1'h0;
        d.hold  = 1'h0;
        d.pdown = 1'h0;
      end
    endcase

    // Serial readout, independent of the conversion timing
    // Data change on the host clock fall, so each bit is settled by the rise
    // at which the host takes it; pin to line takes about three system clocks,
    // so the host clock must run well below the system clock
    if (q.sync.frame_sel_n) begin
      d.oe    = 1'h0;
      d.out_a = 1'h0;
      d.out_b = 1'h0;
    end else begin
      d.oe = 1'h1;
      if (frame_fall) begin
        // Frame start: load both results, top bit first
        d.sh_a  = q.res_a;
        d.sh_b  = q.res_b;
        d.out_a = q.res_a[RES_W-1];
        d.out_b = q.res_b[RES_W-1];
      end else if (sclk_fall) begin
        // Both lines advance on the same host clock edge
        d.sh_a  = q.sh_a << 1;
        d.sh_b  = q.sh_b << 1;
        d.out_a = q.sh_a[RES_W-2];
        d.out_b = q.sh_b[RES_W-2];
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      q                     <= '0;
      q.meta.conv_trigger_n <= `DSC_PIN_IDLE;
      q.meta.frame_sel_n    <= `DSC_PIN_IDLE;
      q.sync.conv_trigger_n <= `DSC_PIN_IDLE;
      q.sync.frame_sel_n    <= `DSC_PIN_IDLE;
      q.prev.conv_trigger_n <= `DSC_PIN_IDLE;
      q.prev.frame_sel_n    <= `DSC_PIN_IDLE;
      // Host clock idles high too; no false edge once reset is released
      q.meta.serial_clk     <= `DSC_PIN_IDLE;
      q.sync.serial_clk     <= `DSC_PIN_IDLE;
      q.prev.serial_clk     <= `DSC_PIN_IDLE;
      q.seq                 <= DSC_IDLE;
      q.pair_cur            <= `DSC_PAIR_DEFAULT;
      q.pair_next           <= `DSC_PAIR_DEFAULT;
      q.span                <= DSC_SPAN_BIP10;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  // Both line drivers share one enable, since the two lines are framed together
  assign BUSY            = q.busy;
  assign HOLD            = q.hold;
  assign POWER_DOWN      = q.pdown;
  assign RESULT_OUT_A    = q.out_a;
  assign RESULT_OUT_A_OE = q.oe;
  assign RESULT_OUT_B    = q.out_b;
  assign RESULT_OUT_B_OE = q.oe;
  assign REF_INTERNAL    = q.ref_int;
  assign SPAN_ACTIVE     = q.span;
  assign SPAN_FAULT      = q.span_bad;
  assign PAIR_ACTIVE     = q.pair_cur;
endmodule : dsc_sequencer

// [verif/dsc_host_model.sv]
// Host side model: trigger, framing and serial clock, captures both result lines
`timescale 1ns/100ps
module dsc_host_model #(
  parameter int W = 14
) (
  input  wire logic    clk,
  input  wire logic    busy,
  input  wire logic    out_a,
  input  wire logic    out_b,
  input  wire logic    oe_a,
  input  wire logic    oe_b,
  output logic         trig_n,
  output logic         frame_n,
  output logic         sclk,
  output logic         got,
  output logic         oe_ok,
  output logic         late,
  output logic [W-1:0] word_a,
  output logic [W-1:0] word_b
);
  // Pins idle high; serial clock stands still outside frames
  initial begin
    trig_n = 1'b1;
    frame_n = 1'b1;
    sclk = 1'b1;
    got = 1'b0;
    late = 1'b0;
  end
  // Bounded wait for a busy level, polled at falling edges
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 200) begin
      @(negedge clk);
      n++;
    end
    // Limit reached without the level: flag it for the bench
    if (busy !== lvl) late = 1'b1;
  endtask : wait_busy
  // One conversion; trigger kept low asks for power-down
  task automatic convert(input bit stay_low);
    @(posedge clk) trig_n <= 1'b0;
    @(negedge clk);
    wait_busy(1'b1);
    @(posedge clk) trig_n <= !stay_low;
    @(negedge clk);
    wait_busy(1'b0);
  endtask : convert
  // Leave power-down by a trigger rise
  task automatic wake();
    @(posedge clk) trig_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : wake
  // Readout frame: MSB at frame fall, then W-1 clock falls, sample on rise
  task automatic read_frame();
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic         ok;
    ok = 1'b1;
    @(posedge clk) frame_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = W - 1; i >= 0; i--) begin
      if (i < W - 1) begin
        sclk <= 1'b0;
        repeat (4) @(posedge clk);
      end
      sclk <= 1'b1;
      a[i] = out_a;
      b[i] = out_b;
      ok = ok & oe_a & oe_b;
      repeat (4) @(posedge clk);
    end
    frame_n <= 1'b1;
    word_a <= a;
    word_b <= b;
    oe_ok <= ok;
    got <= 1'b1;
    @(posedge clk) got <= 1'b0;
  endtask : read_frame
endmodule : dsc_host_model

// [verif/dsc_sequencer_sva.sv]
// Concurrent checks on the ports of the dual converter sequencer
`timescale 1ns/100ps
module dsc_sequencer_sva #(
  parameter int RES_W = 14
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CONV_TRIGGER_N,
  input wire logic FRAME_SEL_N,
  input wire logic SERIAL_CLK,
  input wire logic BUSY,
  input wire logic HOLD,
  input wire logic POWER_DOWN,
  input wire logic RESULT_OUT_A,
  input wire logic RESULT_OUT_A_OE,
  input wire logic RESULT_OUT_B,
  input wire logic RESULT_OUT_B_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // Helper: length of the current busy period
  logic [7:0] busy_cnt_q;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) busy_cnt_q <= 8'h00;
    else busy_cnt_q <= BUSY ? busy_cnt_q + 8'h01 : 8'h00;
  end
  // ==========================================================
  // Assertions
  trig_start_a: assert property ($fell(CONV_TRIGGER_N) && !BUSY && !POWER_DOWN |-> ##[2:4] BUSY)
    else $error("busy did not rise after trigger");
  hold_busy_a: assert property (HOLD == BUSY)
    else $error("hold differs from busy");
  busy_len_a: assert property ($fell(BUSY) |-> busy_cnt_q == 8'(2 * RES_W + 2))
    else $error("busy period has wrong length");
  pdown_entry_a: assert property ($fell(BUSY) |-> POWER_DOWN == !$past(CONV_TRIGGER_N, 3))
    else $error("power-down entry wrong");
  pdown_exit_a: assert property (POWER_DOWN && $rose(CONV_TRIGGER_N) |-> ##[2:5] !POWER_DOWN)
    else $error("power-down not left");
  oe_on_a: assert property ($fell(FRAME_SEL_N) |-> ##[2:4] RESULT_OUT_A_OE && RESULT_OUT_B_OE)
    else $error("drivers not enabled in frame");
  oe_off_a: assert property (FRAME_SEL_N [*5] |-> !RESULT_OUT_A_OE && !RESULT_OUT_B_OE && !RESULT_OUT_A && !RESULT_OUT_B)
    else $error("lines active outside frame");
  shift_wait_a: assert property (!FRAME_SEL_N && $fell(SERIAL_CLK) |-> ($stable(RESULT_OUT_A) && $stable(RESULT_OUT_B)) [*2])
    else $error("data moved before clock edge seen");
  // Main scenarios
  cover property ($rose(BUSY));
  cover property ($fell(BUSY) && POWER_DOWN);
  cover property ($fell(FRAME_SEL_N));
endmodule : dsc_sequencer_sva

// [verif/tb_dsc_sequencer.sv]
// Self-checking bench of the dual converter sequencer driven by a host model
`timescale 1ns/100ps
module tb_dsc_sequencer;
  import dsc_pkg::*;
  localparam int W = 14;
  localparam logic [W-1:0] MSB = 14'h2000;
  localparam logic [W-1:0] BND [4] = '{14'h0000, 14'h3fff, 14'h1fff, 14'h2000};
  // Expected outcome of one conversion
  typedef struct packed {
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic         pair;
    dsc_span_e_t  span;
    logic         fault;
  } dsc_note_t;
  logic        CLK_SYS, RST_N, ref_sel, span0, span1, pair_sel, pair_cur;
  logic [W-1:0] in_a1, in_a2, in_b1, in_b2, va1, va2, vb1, vb2, word_a, word_b;
  logic        trig_n, frame_n, sclk, got, oe_ok, busy, hold, pdown, late;
  logic        out_a, out_a_oe, out_b, out_b_oe, ref_int, span_fault, pair_act;
  logic [1:0]  code;
  logic [31:0] seed;
  dsc_span_e_t span_act, span_cur;
  dsc_note_t   note, cur;
  dsc_note_t   notes[$];
  int          bad_count, num_checks;
  // Clock
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  dsc_sequencer #(.RES_W(W)) dut (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CONV_TRIGGER_N(trig_n), .FRAME_SEL_N(frame_n), .SERIAL_CLK(sclk),
    .REFERENCE_SOURCE_SEL(ref_sel), .INPUT_SPAN_SEL0(span0), .INPUT_SPAN_SEL1(span1), .PAIR_SEL(pair_sel),
    .INPUT_A1(in_a1), .INPUT_A2(in_a2), .INPUT_B1(in_b1), .INPUT_B2(in_b2), .BUSY(busy), .HOLD(hold),
    .POWER_DOWN(pdown), .RESULT_OUT_A(out_a), .RESULT_OUT_A_OE(out_a_oe), .RESULT_OUT_B(out_b),
    .RESULT_OUT_B_OE(out_b_oe), .REF_INTERNAL(ref_int), .SPAN_ACTIVE(span_act), .SPAN_FAULT(span_fault),
    .PAIR_ACTIVE(pair_act));
  dsc_host_model #(.W(W)) host (
    .clk(CLK_SYS), .busy(busy), .out_a(out_a), .out_b(out_b), .oe_a(out_a_oe), .oe_b(out_b_oe),
    .trig_n(trig_n), .frame_n(frame_n), .sclk(sclk), .got(got), .oe_ok(oe_ok), .late(late),
    .word_a(word_a), .word_b(word_b));
  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Count and report one comparison
  task automatic chk(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Compare each finished readout with the oldest note
  always @(negedge CLK_SYS) begin
    if (got === 1'b1) begin
      cur = notes.pop_front();
      chk(word_a === cur.a && word_b === cur.b, "result words");
      chk(oe_ok === 1'b1, "drivers off in frame");
      chk(pair_act === cur.pair, "pair used");
      chk(span_act === cur.span && span_fault === cur.fault, "span");
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    bad_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    RST_N = 1'b0;
    ref_sel = 1'b1;
    {span1, span0, pair_sel, pair_cur} = 4'h0;
    {in_a1, in_a2, in_b1, in_b2} = '0;
    seed = 32'h5aa6ef30;
    span_cur = DSC_SPAN_BIP10;
    repeat (5) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    chk(ref_int === 1'b1, "reference select");
    for (int k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      code = (k < 4) ? 2'(k) : seed[1:0];
      va1 = (k < 4) ? BND[k] : seed[13:0];
      va2 = seed[31:18];
      vb1 = ~va1;
      vb2 = seed[17:4];
      note.a = (pair_cur ? va2 : va1) ^ MSB;
      note.b = (pair_cur ? vb2 : vb1) ^ MSB;
      note.pair = pair_cur;
      note.span = (code == 2'h3) ? span_cur : dsc_span_e_t'(code);
      note.fault = (code == 2'h3);
      span_cur = note.span;
      notes.push_back(note);
      {span1, span0} <= code;
      pair_sel <= seed[2];
      {in_a1, in_a2, in_b1, in_b2} <= {va1, va2, vb1, vb2};
      repeat (2) @(posedge CLK_SYS);
      host.convert(seed[3]);
      chk(pdown === seed[3], "power-down at end");
      chk(late === 1'b0, "busy wait ran out");
      if (seed[3]) host.wake();
      pair_cur = pair_sel;
      host.read_frame();
    end
    repeat (10) @(posedge CLK_SYS);
    chk(notes.size() == 0, "results missing");
    // Second power-up with the external reference strapped
    RST_N   <= 1'b0;
    ref_sel <= 1'b0;
    repeat (5) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (6) @(posedge CLK_SYS);
    chk(ref_int === 1'b0, "reference select after reset");
    chk(pair_act === 1'b0 && busy === 1'b0 && pdown === 1'b0, "state after reset");
    report_and_stop();
  end
endmodule : tb_dsc_sequencer

bind dsc_sequencer dsc_sequencer_sva #(.RES_W(RES_W)) sva (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CONV_TRIGGER_N(CONV_TRIGGER_N), .FRAME_SEL_N(FRAME_SEL_N),
  .SERIAL_CLK(SERIAL_CLK), .BUSY(BUSY), .HOLD(HOLD), .POWER_DOWN(POWER_DOWN), .RESULT_OUT_A(RESULT_OUT_A),
  .RESULT_OUT_A_OE(RESULT_OUT_A_OE), .RESULT_OUT_B(RESULT_OUT_B), .RESULT_OUT_B_OE(RESULT_OUT_B_OE));
